// >>> rtl/line_sync.sv
`timescale 1ns/1ps
module line_sync #(
  parameter int unsigned width = 3
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] level_o
);

  // ==========================================
  // three stage sampling, change taken when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < width; g++)
    begin : bit_g
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      wire agree = (s2_ff == s3_ff);
      always_ff @(posedge clock_i)
      begin
        if (!rst_n_i)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end
        else
        begin
          s1_ff <= async_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          lvl_ff <= agree ? s3_ff : lvl_ff;
        end
      end
      assign level_o[g] = lvl_ff;
    end
  endgenerate

endmodule

// >>> rtl/line_termination_activation_fsm.sv
// Function
// - six states; line silent in ready and pending, training, otherwise steady signal.
// - activate request in ready starts training; elsewhere not expected.
// - section sync in training indicates synced and enters section active.
// - remote ready in section active indicates ready for data, enters tref synced.
// - data valid in tref synced enters steady; not expected earlier.
// - sync loss or deactivation request in active states indicates deact, goes pending.
// - pending state returns to ready once line detect drops, indicating no activity.
// - unlisted events leave the state unchanged.
// - activation must finish within 120 ms plus 10 ms tolerance.
// - without external deactivation control, timer ends operation within 65 ms.
`timescale 1ns/1ps
module line_termination_activation_fsm #(
  parameter longint unsigned act_limit = lt_act_pkg::act_limit_cyc,
  parameter longint unsigned deact_limit = lt_act_pkg::deact_max_cyc
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire lt_act_pkg::exch_req_t exch_req_i,
  input wire logic auto_deact_en_i,
  input wire logic section_sync_i,
  input wire logic remote_ready_info_i,
  input wire logic line_detect_i,
  output lt_act_pkg::exch_ind_t exch_ind_o,
  output lt_act_pkg::tx_mode_t tx_mode_o,
  output lt_act_pkg::lt_state_t state_o
);

  // ==========================================
  // pin synchronisation
  logic [2:0] pins_sync;

  line_sync #(
    .width(3)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({section_sync_i, remote_ready_info_i, line_detect_i}),
    .level_o(pins_sync)
  );

  wire in_sync = pins_sync[2];
  wire remote_ready = pins_sync[1];
  wire line_det = pins_sync[0];

  // ==========================================
  // events from the exchange side
  wire act_evt = exch_req_i.activate_req;
  wire stop_req = exch_req_i.deact_req;
  wire valid_evt = exch_req_i.data_valid;

  // ==========================================
  // timer limits, cut to counter width on purpose
  localparam logic [31:0] act_lim_c = 32'(act_limit);
  localparam logic [31:0] deact_lim_c = 32'(deact_limit);

  // ==========================================
  // state and timers
  lt_act_pkg::lt_state_t state_ff;
  lt_act_pkg::lt_state_t nxt_state;
  lt_act_pkg::exch_ind_t ind_ff;
  lt_act_pkg::exch_ind_t nxt_ind;
  lt_act_pkg::tx_mode_t tx_ff;
  lt_act_pkg::tx_mode_t nxt_tx;
  logic [31:0] act_cnt_ff;
  logic [31:0] loss_cnt_ff;

  // ==========================================
  // state decode
  wire st_training = (state_ff == lt_act_pkg::lt_training);
  wire st_sect = (state_ff == lt_act_pkg::lt_section_active);
  wire st_tref = (state_ff == lt_act_pkg::lt_tref_synced);
  wire st_steady = (state_ff == lt_act_pkg::lt_steady);
  wire st_pend = (state_ff == lt_act_pkg::lt_pending_deact);

  wire is_active = st_training || st_sect || st_tref || st_steady;
  wire is_act_phase = is_active && !st_steady;
  wire act_expired = is_act_phase && (act_cnt_ff >= act_lim_c);
  wire loss_expired = (loss_cnt_ff >= deact_lim_c);
  wire auto_stop = auto_deact_en_i && act_expired;
  // sync is only lost once it was gained, so training is left out
  wire past_training = is_active && !st_training;
  wire loss_pend = auto_deact_en_i && !in_sync && past_training;
  wire loss_now = !auto_deact_en_i && !in_sync && !st_training;
  wire loss_late = auto_deact_en_i && loss_expired;
  wire train_stop = stop_req || auto_stop;
  wire deact_evt = stop_req || loss_now || loss_late || auto_stop;

  // ==========================================
  // next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      lt_act_pkg::lt_ready:
      begin
        if (act_evt)
        begin
          nxt_state = lt_act_pkg::lt_training;
        end
      end
      lt_act_pkg::lt_training:
      begin
        if (train_stop)
        begin
          nxt_state = lt_act_pkg::lt_pending_deact;
        end
        else if (in_sync)
        begin
          nxt_state = lt_act_pkg::lt_section_active;
        end
      end
      lt_act_pkg::lt_section_active, lt_act_pkg::lt_tref_synced, lt_act_pkg::lt_steady:
      begin
        if (deact_evt)
        begin
          nxt_state = lt_act_pkg::lt_pending_deact;
        end
        else if (st_sect && remote_ready)
        begin
          nxt_state = lt_act_pkg::lt_tref_synced;
        end
        else if (st_tref && valid_evt)
        begin
          nxt_state = lt_act_pkg::lt_steady;
        end
      end
      lt_act_pkg::lt_pending_deact:
      begin
        if (!line_det)
        begin
          nxt_state = lt_act_pkg::lt_ready;
        end
      end
      default:
      begin
        nxt_state = lt_act_pkg::lt_ready;
      end
    endcase
  end

  // ==========================================
  // indications, one cycle pulse on each transition except entry to training and entry to steady
  wire nxt_sect = (nxt_state == lt_act_pkg::lt_section_active);
  wire nxt_tref = (nxt_state == lt_act_pkg::lt_tref_synced);
  wire nxt_pend = (nxt_state == lt_act_pkg::lt_pending_deact);
  wire nxt_idle = (nxt_state == lt_act_pkg::lt_ready);
  wire to_synced = st_training && nxt_sect;
  wire to_ready_data = st_sect && nxt_tref;
  wire to_pending = !st_pend && nxt_pend;
  wire to_idle = st_pend && nxt_idle;
  wire to_timeout = to_pending && auto_stop;

  assign nxt_ind = '{
    section_synced_ind: to_synced,
    ready_for_data_ind: to_ready_data,
    deact_ind: to_pending,
    no_activity_ind: to_idle,
    act_timeout_ind: to_timeout
  };

  // ==========================================
  // line output selection
  always_comb
  begin
    case (nxt_state)
      lt_act_pkg::lt_training: nxt_tx = lt_act_pkg::tx_training;
      lt_act_pkg::lt_section_active,
      lt_act_pkg::lt_tref_synced,
      lt_act_pkg::lt_steady: nxt_tx = lt_act_pkg::tx_steady;
      default: nxt_tx = lt_act_pkg::tx_inactive;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= lt_act_pkg::lt_ready;
      ind_ff <= '0;
      tx_ff <= lt_act_pkg::tx_inactive;
    end
    else
    begin
      state_ff <= nxt_state;
      ind_ff <= nxt_ind;
      tx_ff <= nxt_tx;
    end
  end

  // activation timer, runs from activate request until steady
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !is_act_phase)
    begin
      act_cnt_ff <= '0;
    end
    else if (!act_expired)
    begin
      act_cnt_ff <= act_cnt_ff + 32'h1;
    end
  end

  // sync loss timer
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !loss_pend)
    begin
      loss_cnt_ff <= '0;
    end
    else if (!loss_expired)
    begin
      loss_cnt_ff <= loss_cnt_ff + 32'h1;
    end
  end

  assign exch_ind_o = ind_ff;
  assign tx_mode_o = tx_ff;
  assign state_o = state_ff;

endmodule

// >>> rtl/lt_act_pkg.sv
package lt_act_pkg;

  // ==========================================
  // states
  typedef enum logic [2:0] {
    lt_ready          = 3'h0,
    lt_training       = 3'h1,
    lt_section_active = 3'h2,
    lt_tref_synced    = 3'h3,
    lt_steady         = 3'h4,
    lt_pending_deact  = 3'h5
  } lt_state_t;

  // ==========================================
  // line transmit selection
  typedef enum logic [1:0] {
    tx_inactive = 2'h0,
    tx_training = 2'h1,
    tx_steady   = 2'h2
  } tx_mode_t;

  // ==========================================
  // events from the exchange side
  typedef struct packed {
    logic activate_req;
    logic deact_req;
    logic data_valid;
  } exch_req_t;

  // indications to the exchange side
  typedef struct packed {
    logic section_synced_ind;
    logic ready_for_data_ind;
    logic deact_ind;
    logic no_activity_ind;
    logic act_timeout_ind;
  } exch_ind_t;

  // ==========================================
  // timing
  localparam int unsigned clk_mhz = 200;
  localparam int unsigned act_nom_ms = 120;
  localparam int unsigned act_tol_ms = 10;
  localparam int unsigned deact_max_ms = 65;
  localparam longint unsigned act_limit_cyc =
    longint'(act_nom_ms + act_tol_ms) * 1000 * clk_mhz;
  localparam longint unsigned deact_max_cyc =
    longint'(deact_max_ms) * 1000 * clk_mhz;
  localparam int unsigned sync_stages = 3;

endpackage

// >>> verif/lt_act_sva.sv
`timescale 1ns/1ps
module lt_act_sva #(
  parameter longint unsigned act_limit = 200,
  parameter longint unsigned deact_limit = 100
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire lt_act_pkg::exch_req_t exch_req_i,
  input wire logic auto_deact_en_i,
  input wire logic section_sync_i,
  input wire logic remote_ready_info_i,
  input wire logic line_detect_i,
  input wire lt_act_pkg::exch_ind_t exch_ind_o,
  input wire lt_act_pkg::tx_mode_t tx_mode_o,
  input wire lt_act_pkg::lt_state_t state_o
);
  // ==========================================
  // state and indication checks
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  wire [2:0] st = state_o;
  wire [1:0] tx = tx_mode_o;
  wire [4:0] ind = exch_ind_o;
  wire [1:0] exp_tx = (st == 3'h1) ? 2'h1 : (st == 3'h0 || st == 3'h5) ? 2'h0 : 2'h2;
  sequence s_pend_lit;
    (st == 3'h5 && line_detect_i) [*5];
  endsequence
  a_tx_map: assert property (tx == exp_tx)
    else $error("tx mode wrong");
  a_act_start: assert property (st == 3'h0 && exch_req_i == 3'h4 |=> st == 3'h1)
    else $error("no training");
  a_sync_ind: assert property (ind[4] |-> st == 3'h2 && $past(st) == 3'h1)
    else $error("bad synced pulse");
  a_ready_ind: assert property (ind[3] |-> st == 3'h3 && $past(st) == 3'h2)
    else $error("bad ready pulse");
  a_deact_go: assert property (exch_req_i.deact_req && st inside {[3'h1:3'h4]}
    |=> st == 3'h5 && ind[2]) else $error("no deact");
  a_idle_exit: assert property (ind[1] |-> st == 3'h0 && $past(st) == 3'h5)
    else $error("bad idle pulse");
  a_pend_hold: assert property (s_pend_lit |=> st == 3'h5)
    else $error("left pending");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i
    |=> st == 3'h0 && ind == 5'h00 && tx == 2'h0) else $error("reset not quiet");
  // cycles spent activating
  logic [31:0] act_cyc;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !(st inside {3'h1, 3'h2, 3'h3}))
    begin
      act_cyc <= '0;
    end
    else
    begin
      act_cyc <= act_cyc + 32'h1;
    end
  end
  a_steady_entry: assert property (st == 3'h4 && $past(st) != 3'h4
    |-> $past(st) == 3'h3 && $past(exch_req_i.data_valid)) else $error("bad steady entry");
  a_timeout_pair: assert property (ind[0] |-> ind[2] && st == 3'h5)
    else $error("timeout without deact");
  a_act_bound: assert property (auto_deact_en_i && st inside {[3'h1:3'h3]}
    |-> act_cyc <= 32'(act_limit)) else $error("activation too long");
endmodule
bind line_termination_activation_fsm lt_act_sva #(.act_limit(act_limit),
  .deact_limit(deact_limit)) i_lt_act_sva (.clock_i, .rst_n_i, .exch_req_i,
  .auto_deact_en_i, .section_sync_i, .remote_ready_info_i, .line_detect_i,
  .exch_ind_o, .tx_mode_o, .state_o);

// >>> verif/remote_model.sv
`timescale 1ns/1ps
module remote_model (
  input wire logic clock_i,
  input wire lt_act_pkg::tx_mode_t tx_mode_i,
  input wire logic [7:0] delay_i,
  input wire logic sync_kill_i,
  output logic section_sync_o,
  output logic remote_ready_o,
  output logic line_detect_o
);
  // ==========================================
  // far end reacting to line signal
  lt_act_pkg::tx_mode_t last_ff = lt_act_pkg::tx_inactive;
  logic [8:0] cnt_ff = 9'h000;
  wire up = cnt_ff >= {1'b0, delay_i};
  wire trn = tx_mode_i == lt_act_pkg::tx_training;
  wire stdy = tx_mode_i == lt_act_pkg::tx_steady;
  always_ff @(posedge clock_i)
  begin
    last_ff <= tx_mode_i;
    cnt_ff <= (tx_mode_i !== last_ff) ? 9'h000 : cnt_ff + 9'(cnt_ff != 9'h1ff);
    section_sync_o <= !sync_kill_i && (trn ? up : stdy);
    remote_ready_o <= stdy && up;
    line_detect_o <= trn || stdy || cnt_ff < {1'b0, delay_i} + 9'h008;
  end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================
  // harness
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  lt_act_pkg::exch_req_t req = 3'h0;
  logic auto_en = 1'b0;
  logic kill = 1'b0;
  logic [7:0] dly = 8'h02;
  logic sync, rdy, line_detect;
  lt_act_pkg::exch_ind_t ind;
  lt_act_pkg::tx_mode_t tx;
  lt_act_pkg::lt_state_t st;
  int err_count = 0;
  int num_checks = 0;
  always #2.5 clock_i = ~clock_i;
  line_termination_activation_fsm #(.act_limit(200), .deact_limit(100))
    i_line_termination_activation_fsm (.clock_i, .rst_n_i, .exch_req_i(req),
    .auto_deact_en_i(auto_en), .section_sync_i(sync), .remote_ready_info_i(rdy),
    .line_detect_i(line_detect), .exch_ind_o(ind), .tx_mode_o(tx), .state_o(st));
  remote_model i_remote_model (.clock_i, .tx_mode_i(tx), .delay_i(dly),
    .sync_kill_i(kill), .section_sync_o(sync), .remote_ready_o(rdy), .line_detect_o(line_detect));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic go(input lt_act_pkg::lt_state_t s, input int n);
    int i;
    i = 0;
    while (st !== s && i < n)
    begin
      @(posedge clock_i);
      #1;
      i++;
    end
    chk("st", 8'(s), 8'(st));
  endtask
  task automatic send(input lt_act_pkg::exch_req_t r);
    @(posedge clock_i);
    req <= r;
    @(posedge clock_i);
    req <= 3'h0;
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_act(input logic [7:0] d);
    @(posedge clock_i);
    dly <= d;
    send(3'h4);
    chk("tx", 8'h01, 8'(tx));
    go(lt_act_pkg::lt_section_active, 400);
    chk("ind", 8'h10, 8'(ind));
    chk("tx", 8'h02, 8'(tx));
    go(lt_act_pkg::lt_tref_synced, 400);
    chk("ind", 8'h08, 8'(ind));
    send(3'h1);
    chk("st", 8'h04, 8'(st));
  endtask
  task automatic t_deact;
    send(3'h2);
    chk("ind", 8'h04, 8'(ind));
    chk("tx", 8'h00, 8'(tx));
    send(3'h4);
    chk("st", 8'h05, 8'(st));
    go(lt_act_pkg::lt_ready, 400);
    chk("ind", 8'h02, 8'(ind));
  endtask
  task automatic t_loss;
    t_act(8'h28);
    @(posedge clock_i);
    kill <= 1'b1;
    go(lt_act_pkg::lt_pending_deact, 10);
    chk("ind", 8'h04, 8'(ind));
    kill <= 1'b0;
    go(lt_act_pkg::lt_ready, 400);
  endtask
  task automatic t_timeout;
    @(posedge clock_i);
    auto_en <= 1'b1;
    dly <= 8'hff;
    send(3'h4);
    repeat (190) @(posedge clock_i);
    #1;
    chk("st", 8'h01, 8'(st));
    go(lt_act_pkg::lt_pending_deact, 20);
    chk("ind", 8'h05, 8'(ind));
    go(lt_act_pkg::lt_ready, 400);
  endtask
  task automatic t_auto_loss;
    t_act(8'h02);
    @(posedge clock_i);
    kill <= 1'b1;
    repeat (90) @(posedge clock_i);
    #1;
    chk("st", 8'h04, 8'(st));
    go(lt_act_pkg::lt_pending_deact, 30);
    chk("ind", 8'h04, 8'(ind));
    kill <= 1'b0;
    go(lt_act_pkg::lt_ready, 400);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    chk("ind", 8'h00, 8'(ind));
    send(3'h3);
    chk("st", 8'h00, 8'(st));
    t_act(8'h02);
    t_deact;
    t_loss;
    t_timeout;
    t_auto_loss;
    final_report;
  end
  initial
  begin
    #20000;
    err_count++;
    final_report;
  end
endmodule
